// File: sw_pkg.sv
// constants for the sweep trigger and pin routing block
package sw_pkg;

  // geometry
  localparam int IDX_W  = 7;
  localparam int ADDR_W = IDX_W + 2;
  localparam int N_REGS = 17;
  localparam int N_PINS = 4;

  // register indices, byte address is four times the index
  localparam logic [6:0] FIRST_IDX  = 7'h3A;
  localparam logic [6:0] LAST_IDX   = 7'h4A;
  localparam logic [6:0] CTRL_IDX   = 7'h3A;
  localparam logic [6:0] EVBC_IDX   = 7'h3B;
  localparam logic [6:0] THR0_IDX   = 7'h3C;
  localparam logic [6:0] MASK0_IDX  = 7'h40;
  localparam logic [6:0] THR1_IDX   = 7'h41;
  localparam logic [6:0] MASK1_IDX  = 7'h45;
  localparam logic [6:0] TOP_IDX    = 7'h46;
  localparam logic [6:0] DEV_IDX    = 7'h47;
  localparam logic [6:0] ROUTE_IDX  = 7'h50;
  localparam logic [6:0] DEVSEL_IDX = 7'h54;
  localparam logic [6:0] FBLOW_IDX  = 7'h55;
  localparam logic [6:0] STAT_IDX   = 7'h56;

  // field positions
  localparam int EN_BIT     = 0;
  localparam int CLKSEL_BIT = 1;
  localparam int PM_BIT     = 2;
  localparam int EVA_LSB    = 4;
  localparam int EVB_LSB    = 0;
  localparam int EVC_LSB    = 4;
  localparam int TOP_THR0   = 0;
  localparam int TOP_THR1   = 1;
  localparam int TOP_DEV    = 2;

  // reset values
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [5:0] ROUTE_RST  = 6'h00;
  localparam logic [1:0] DEVSEL_RST = 2'h0;

  // fixed modulator denominator while sweeping
  localparam logic [24:0] DEN_FIXED = 25'h1000000;

  // event source codes
  localparam logic [3:0] SRC_NEVER   = 4'h0;
  localparam logic [3:0] SRC_T1_RISE = 4'h1;
  localparam logic [3:0] SRC_HIT0    = 4'h5;
  localparam logic [3:0] SRC_GAIN_R  = 4'h6;
  localparam logic [3:0] SRC_FLAG_R  = 4'h7;
  localparam logic [3:0] SRC_ALWAYS  = 4'h8;
  localparam logic [3:0] SRC_T1_FALL = 4'h9;
  localparam logic [3:0] SRC_HIT1    = 4'hD;
  localparam logic [3:0] SRC_GAIN_F  = 4'hE;
  localparam logic [3:0] SRC_FLAG_F  = 4'hF;

  // deviation trigger codes
  localparam logic [1:0] DEV_ALWAYS = 2'h0;
  localparam logic [1:0] DEV_EVA    = 2'h1;
  localparam logic [1:0] DEV_EVB    = 2'h2;

  // pin route codes
  localparam logic [5:0]  RT_GND     = 6'h00;
  localparam logic [5:0]  RT_IN_T1   = 6'h01;
  localparam logic [5:0]  RT_IN_T2   = 6'h02;
  localparam logic [5:0]  RT_IN_KEY  = 6'h03;
  localparam logic [5:0]  RT_LOCK    = 6'h0A;
  localparam logic [5:0]  RT_RSV_LO  = 6'h27;
  localparam logic [63:0] DRIVE_MASK = 64'h0000007FF0CFFFF1;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: sync_edge.sv
// two-flop synchroniser with rising edge detect
`timescale 1ns/10ps
module sync_edge #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // asynchronous inputs
  input  wire logic [W-1:0] async_in,
  // synchronised level and edge
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sy_t;

  sy_t s;
  sy_t d;

  // shift chain, first stage feeds only the second
  always_comb begin
    d    = s;
    d.s1 = async_in;
    d.s2 = s.s1;
    d.s3 = s.s2;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  // outputs from the second and third stages
  assign level = s.s2;
  assign rise  = s.s2 & ~s.s3;

endmodule

// File: sweep_trigger.sv
// sweep trigger events, comparators, deviation and pin routing
//
// Contract
// - four pins, 6-bit route each, reserved codes
// - codes 4-7 synced pins and readback
// - code 10 combined lock, 11 lock detect
// - codes 12-14 pump monitor, 15 limit
// - codes 28-38 sweep and pump signals
// - sweep enabled fixes denominator at 2^24
// - low feedback byte write starts segment 0
// - sweep clock from detector clock or key
// - events A, B, C each own source
// - source codes 0-8 rising edges, levels
// - source codes 9-15 falling edges, levels
// - comparator 0 has 33-bit signed threshold
// - comparator 0 per-segment enable mask
// - comparator 1 same as comparator 0
// - deviation trigger selects always or event
// - 33-bit deviation, frequency or phase type
`timescale 1ns/10ps
module sweep_trigger (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [8:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [8:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // multipurpose pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe_n,
  // asynchronous analog-side inputs
  input  wire logic        pd_clock,
  input  wire logic        ref_div_out,
  input  wire logic        fb_div_out,
  input  wire logic        phase_lock_detect,
  input  wire logic        pump_monitor_good,
  input  wire logic        pump_monitor_high,
  input  wire logic        pump_monitor_low,
  input  wire logic        pump_up_pulse,
  input  wire logic        pump_down_pulse,
  // sweep engine inputs on aclk
  input  wire logic [32:0] sweep_value,
  input  wire logic [2:0]  segment_index,
  input  wire logic        segment_pump_gain,
  input  wire logic        segment_flag_zero,
  input  wire logic        segment_flag_one,
  input  wire logic        fast_lock_active,
  input  wire logic        limit_exceeded,
  input  wire logic        repeat_count_done,
  input  wire logic        readback_data,
  input  wire logic [23:0] programmed_denominator,
  // sweep control outputs
  output logic             sweep_enable,
  output logic             sweep_tick,
  output logic             sweep_start,
  output logic             event_a,
  output logic             event_b,
  output logic             event_c,
  output logic             comparator_zero_hit,
  output logic             comparator_one_hit,
  output logic      [32:0] freq_deviation,
  output logic      [32:0] phase_deviation,
  output logic      [24:0] modulator_denominator
);

  localparam int NR = sw_pkg::N_REGS;
  localparam int NP = sw_pkg::N_PINS;

  typedef struct packed {
    logic [NR-1:0][7:0] regs;
    logic [NP-1:0][5:0] route;
    logic [1:0]         dev_sel;
    logic [7:0]         fb_low;
    logic               aw_got;
    logic               w_got;
    logic [6:0]         aw_idx;
    logic [7:0]         w_byte;
    logic               w_lane;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [7:0]         rdata;
    logic [5:0]         src_prev;
    logic               key_prev;
    logic [1:0]         ref_cnt;
    logic [1:0]         fb_cnt;
    logic               tick;
    logic               start;
    logic               ev_a;
    logic               ev_b;
    logic               ev_c;
    logic               hit0;
    logic               hit1;
    logic [NP-1:0]      pin_out;
    logic [NP-1:0]      pin_oe_n;
    logic [32:0]        fm_dev;
    logic [32:0]        pm_dev;
    logic [24:0]        denom;
  } state_t;

  state_t s;
  state_t d;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [12:0]   a_lvl;
  logic [12:0]   a_rise;
  logic [NP-1:0] pins_s;
  logic          pd_s;
  logic          ref_s;
  logic          fb_s;
  logic          lock_s;
  logic          good_s;
  logic          high_s;
  logic          low_s;
  logic          up_s;
  logic          dn_s;

  sync_edge #(
    .W (13)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pump_down_pulse, pump_up_pulse, pump_monitor_low,
                pump_monitor_high, pump_monitor_good, phase_lock_detect,
                fb_div_out, ref_div_out, pd_clock, pin_in}),
    .level    (a_lvl),
    .rise     (a_rise)
  );

  // unpack synchronised levels
  assign {dn_s, up_s, low_s, high_s, good_s, lock_s,
          fb_s, ref_s, pd_s, pins_s} = a_lvl;

  ////////////////////////////////////////////////////////////////////////
  // register fields

  logic [7:0]  ctrl;
  logic [7:0]  evbc;
  logic [7:0]  top;
  logic [32:0] thr0;
  logic [32:0] thr1;
  logic [7:0]  mask0;
  logic [7:0]  mask1;
  logic [32:0] dev;

  // field views of the register array
  assign ctrl  = s.regs[sw_pkg::CTRL_IDX - sw_pkg::FIRST_IDX];
  assign evbc  = s.regs[sw_pkg::EVBC_IDX - sw_pkg::FIRST_IDX];
  assign top   = s.regs[sw_pkg::TOP_IDX - sw_pkg::FIRST_IDX];
  assign mask0 = s.regs[sw_pkg::MASK0_IDX - sw_pkg::FIRST_IDX];
  assign mask1 = s.regs[sw_pkg::MASK1_IDX - sw_pkg::FIRST_IDX];
  assign thr0  = {top[sw_pkg::TOP_THR0],
                  s.regs[sw_pkg::THR0_IDX - sw_pkg::FIRST_IDX + 3],
                  s.regs[sw_pkg::THR0_IDX - sw_pkg::FIRST_IDX + 2],
                  s.regs[sw_pkg::THR0_IDX - sw_pkg::FIRST_IDX + 1],
                  s.regs[sw_pkg::THR0_IDX - sw_pkg::FIRST_IDX]};
  assign thr1  = {top[sw_pkg::TOP_THR1],
                  s.regs[sw_pkg::THR1_IDX - sw_pkg::FIRST_IDX + 3],
                  s.regs[sw_pkg::THR1_IDX - sw_pkg::FIRST_IDX + 2],
                  s.regs[sw_pkg::THR1_IDX - sw_pkg::FIRST_IDX + 1],
                  s.regs[sw_pkg::THR1_IDX - sw_pkg::FIRST_IDX]};
  assign dev   = {top[sw_pkg::TOP_DEV],
                  s.regs[sw_pkg::DEV_IDX - sw_pkg::FIRST_IDX + 3],
                  s.regs[sw_pkg::DEV_IDX - sw_pkg::FIRST_IDX + 2],
                  s.regs[sw_pkg::DEV_IDX - sw_pkg::FIRST_IDX + 1],
                  s.regs[sw_pkg::DEV_IDX - sw_pkg::FIRST_IDX]};

  ////////////////////////////////////////////////////////////////////////
  // pin routing

  logic [63:0]   out_vec;
  logic [NP-1:0] in_t1;
  logic [NP-1:0] in_t2;
  logic [NP-1:0] in_key;
  logic [NP-1:0] drv;
  logic [NP-1:0] lvl;
  logic          trig_one;
  logic          trig_two;
  logic          key;

  // signals selectable onto a pin, indexed by route code
  assign out_vec = {25'h0000000,
    repeat_count_done, dn_s, up_s, ref_s,
    s.ev_c, s.ev_b, s.ev_a, segment_flag_one,
    segment_flag_zero, segment_pump_gain, fast_lock_active,
    4'h0, s.hit1, s.hit0, 2'h0,
    s.fb_cnt[1], s.fb_cnt[0], s.ref_cnt[1], s.ref_cnt[0],
    limit_exceeded, low_s, high_s, good_s,
    lock_s, lock_s & good_s,
    s.hit1 | ~mask1[segment_index], s.hit0 | ~mask0[segment_index],
    readback_data, key, trig_two, trig_one,
    4'h0};

  // per-pin input selection and output drive
  for (genvar p = 0; p < NP; p++) begin : g_pin
    assign in_t1[p]  = (s.route[p] == sw_pkg::RT_IN_T1) & pins_s[p];
    assign in_t2[p]  = (s.route[p] == sw_pkg::RT_IN_T2) & pins_s[p];
    assign in_key[p] = (s.route[p] == sw_pkg::RT_IN_KEY) & pins_s[p];
    assign drv[p]    = sw_pkg::DRIVE_MASK[s.route[p]];
    assign lvl[p]    = out_vec[s.route[p]];
  end

  assign trig_one = |in_t1;
  assign trig_two = |in_t2;
  assign key      = |in_key;

  ////////////////////////////////////////////////////////////////////////
  // sweep clock, edges and comparators

  logic       key_rise;
  logic       tick;
  logic [5:0] src;
  logic [5:0] rise;
  logic [5:0] fall;
  logic       raw0;
  logic       raw1;
  logic       hit0;
  logic       hit1;

  // tick from detector clock or keying pin edge
  assign key_rise = key & ~s.key_prev;
  assign tick = ctrl[sw_pkg::CLKSEL_BIT] ? key_rise : a_rise[4];

  // edges sampled once per sweep tick
  assign src  = {segment_flag_zero, segment_pump_gain, lock_s,
                 key, trig_two, trig_one};
  assign rise = {6{tick}} & src & ~s.src_prev;
  assign fall = {6{tick}} & ~src & s.src_prev;

  // signed compares gated by the segment masks
  assign raw0 = $signed(sweep_value) >= $signed(thr0);
  assign raw1 = $signed(sweep_value) >= $signed(thr1);
  assign hit0 = raw0 & mask0[segment_index];
  assign hit1 = raw1 & mask1[segment_index];

  // event from a 4-bit source code
  function automatic logic pick(input logic [3:0] c);
    logic v;
    v = 1'b0;
    case (c)
      sw_pkg::SRC_NEVER:  v = 1'b0;
      sw_pkg::SRC_HIT0:   v = hit0;
      sw_pkg::SRC_GAIN_R: v = rise[4];
      sw_pkg::SRC_FLAG_R: v = rise[5];
      sw_pkg::SRC_ALWAYS: v = 1'b1;
      sw_pkg::SRC_HIT1:   v = hit1;
      sw_pkg::SRC_GAIN_F: v = fall[4];
      sw_pkg::SRC_FLAG_F: v = fall[5];
      default: v = (c < sw_pkg::SRC_ALWAYS) ?
                   rise[2'(c - sw_pkg::SRC_T1_RISE)] :
                   fall[2'(c - sw_pkg::SRC_T1_FALL)];
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic       fb_wr;
  logic [6:0] widx;
  logic [6:0] ridx;

  assign widx  = s.aw_idx;
  assign ridx  = araddr[8:2];
  assign fb_wr = s.aw_got & s.w_got & ~s.bvalid & s.w_lane &
                 (widx == sw_pkg::FBLOW_IDX);

  // bus slave, events, deviation and pin drive
  always_comb begin
    logic dev_act;
    logic ok;
    dev_act  = 1'b0;
    ok       = 1'b1;
    d        = s;
    d.tick   = tick;
    d.src_prev = tick ? src : s.src_prev;
    d.key_prev = key;
    d.ref_cnt  = s.ref_cnt + {1'b0, a_rise[5]};
    d.fb_cnt   = s.fb_cnt + {1'b0, a_rise[6]};
    d.ev_a = pick(ctrl[sw_pkg::EVA_LSB +: 4]);
    d.ev_b = pick(evbc[sw_pkg::EVB_LSB +: 4]);
    d.ev_c = pick(evbc[sw_pkg::EVC_LSB +: 4]);
    d.hit0 = hit0;
    d.hit1 = hit1;
    d.pin_out  = lvl;
    d.pin_oe_n = ~drv;
    d.start    = fb_wr & ctrl[sw_pkg::EN_BIT];
    d.denom    = ctrl[sw_pkg::EN_BIT] ? sw_pkg::DEN_FIXED :
                 {1'b0, programmed_denominator};
    // deviation applied while its trigger is active
    case (s.dev_sel)
      sw_pkg::DEV_ALWAYS: dev_act = 1'b1;
      sw_pkg::DEV_EVA:    dev_act = d.ev_a;
      sw_pkg::DEV_EVB:    dev_act = d.ev_b;
      default:            dev_act = d.ev_c;
    endcase
    d.fm_dev = (dev_act & ~ctrl[sw_pkg::PM_BIT]) ? dev : '0;
    d.pm_dev = (dev_act & ctrl[sw_pkg::PM_BIT]) ? dev : '0;
    // write address and data captured in either order
    if (awvalid & s.awready) begin
      d.awready = 1'b0;
      d.aw_got  = 1'b1;
      d.aw_idx  = awaddr[8:2];
    end
    if (wvalid & s.wready) begin
      d.wready = 1'b0;
      d.w_got  = 1'b1;
      d.w_byte = wdata[7:0];
      d.w_lane = wstrb[0];
    end
    // commit write once both halves are held
    if (s.aw_got & s.w_got & ~s.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      if (widx >= sw_pkg::FIRST_IDX && widx <= sw_pkg::LAST_IDX) begin
        if (s.w_lane) begin
          d.regs[widx - sw_pkg::FIRST_IDX] = s.w_byte;
        end
      end else if (widx >= sw_pkg::ROUTE_IDX &&
                   widx < sw_pkg::ROUTE_IDX + 7'(NP)) begin
        if (s.w_lane) begin
          d.route[2'(widx - sw_pkg::ROUTE_IDX)] = s.w_byte[5:0];
        end
      end else if (widx == sw_pkg::DEVSEL_IDX) begin
        if (s.w_lane) begin
          d.dev_sel = s.w_byte[1:0];
        end
      end else if (widx == sw_pkg::FBLOW_IDX) begin
        if (s.w_lane) begin
          d.fb_low = s.w_byte;
        end
      end else if (widx != sw_pkg::STAT_IDX) begin
        ok = 1'b0;
      end
      d.bresp = ok ? sw_pkg::RESP_OKAY : sw_pkg::RESP_SLVERR;
    end
    if (s.bvalid & bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end
    // read decode
    if (arvalid & s.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = 8'h00;
      d.rresp   = sw_pkg::RESP_OKAY;
      if (ridx >= sw_pkg::FIRST_IDX && ridx <= sw_pkg::LAST_IDX) begin
        d.rdata = s.regs[ridx - sw_pkg::FIRST_IDX];
      end else if (ridx >= sw_pkg::ROUTE_IDX &&
                   ridx < sw_pkg::ROUTE_IDX + 7'(NP)) begin
        d.rdata = {2'h0, s.route[2'(ridx - sw_pkg::ROUTE_IDX)]};
      end else if (ridx == sw_pkg::DEVSEL_IDX) begin
        d.rdata = {6'h00, s.dev_sel};
      end else if (ridx == sw_pkg::FBLOW_IDX) begin
        d.rdata = s.fb_low;
      end else if (ridx == sw_pkg::STAT_IDX) begin
        d.rdata = {2'h0, s.ev_c, s.ev_b, s.ev_a,
                   lock_s & good_s, s.hit1, s.hit0};
      end else begin
        d.rresp = sw_pkg::RESP_SLVERR;
      end
    end
    if (s.rvalid & rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
  end

  // state register, readies open after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.regs    <= {NR{sw_pkg::REG_RST}};
      s.route   <= {NP{sw_pkg::ROUTE_RST}};
      s.dev_sel <= sw_pkg::DEVSEL_RST;
      s.pin_oe_n <= '1;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready  = s.awready;
  assign wready   = s.wready;
  assign bvalid   = s.bvalid;
  assign bresp    = s.bresp;
  assign arready  = s.arready;
  assign rvalid   = s.rvalid;
  assign rresp    = s.rresp;
  assign rdata    = {24'h000000, s.rdata};
  assign pin_out  = s.pin_out;
  assign pin_oe_n = s.pin_oe_n;
  assign sweep_enable = ctrl[sw_pkg::EN_BIT];
  assign sweep_tick   = s.tick;
  assign sweep_start  = s.start;
  assign event_a  = s.ev_a;
  assign event_b  = s.ev_b;
  assign event_c  = s.ev_c;
  assign comparator_zero_hit = s.hit0;
  assign comparator_one_hit  = s.hit1;
  assign freq_deviation  = s.fm_dev;
  assign phase_deviation = s.pm_dev;
  assign modulator_denominator = s.denom;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fm_dev_s;
    s.dev_sel == sw_pkg::DEV_ALWAYS && !ctrl[sw_pkg::PM_BIT];
  endsequence

  sequence t1_fall_s;
    evbc[sw_pkg::EVB_LSB +: 4] == sw_pkg::SRC_T1_FALL &&
    tick && s.src_prev[0] && !trig_one;
  endsequence

  den_fixed_a: assert property (ctrl[sw_pkg::EN_BIT] |=>
    modulator_denominator == sw_pkg::DEN_FIXED)
    else $error("denominator not fixed while sweeping");
  start_pulse_a: assert property (sweep_start ==
    $past(fb_wr && ctrl[sw_pkg::EN_BIT]))
    else $error("sweep start not tied to feedback write");
  tick_src_a: assert property (!ctrl[sw_pkg::CLKSEL_BIT] &&
    !a_rise[4] |=> !sweep_tick)
    else $error("tick without detector clock edge");
  never_src_a: assert property (
    ctrl[sw_pkg::EVA_LSB +: 4] == sw_pkg::SRC_NEVER |=> !event_a)
    else $error("event a fired with never source");
  always_src_a: assert property (
    evbc[sw_pkg::EVC_LSB +: 4] == sw_pkg::SRC_ALWAYS |=> event_c)
    else $error("event c missing with always source");
  fall_edge_a: assert property (t1_fall_s |=> event_b)
    else $error("falling edge of pin one missed");
  seg_mask_a: assert property (!mask0[segment_index] |=>
    !comparator_zero_hit)
    else $error("comparator 0 hit in masked segment");
  dev_apply_a: assert property (fm_dev_s |=>
    freq_deviation == $past(dev) && phase_deviation == '0)
    else $error("frequency deviation not applied");
  pin_gnd_a: assert property (s.route[0] == sw_pkg::RT_GND |=>
    !pin_out[0] && !pin_oe_n[0])
    else $error("ground route not driving low");
  pin_rsv_a: assert property (s.route[1] >= sw_pkg::RT_RSV_LO |=>
    pin_oe_n[1])
    else $error("reserved route drives the pin");
  lock_out_a: assert property (s.route[3] == sw_pkg::RT_LOCK |=>
    pin_out[3] == $past(lock_s && good_s))
    else $error("combined lock route wrong");

endmodule

// File: pin_far.sv
// far side model of the four pins
`timescale 1ns/10ps
module pin_far (
  // block side
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  // external sources
  input  wire logic [3:0] ext_lvl,
  output logic      [3:0] pin_in
);
  // a pin the block drives shows its level, else the source
  assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule

// File: sweep_trigger_test.sv
// self-checking bench for the sweep trigger block
`timescale 1ns/10ps
module sweep_trigger_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tk, eb;
  logic        awready, wready, bvalid, arready, rvalid, en, start, ea, hit0;
  logic [8:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, pin_in, pin_out, pin_oe_n, ext;
  logic [1:0]  bresp, rresp;
  logic [15:0] ana;
  logic [32:0] sweep_value, fdev, pdev;
  logic [2:0]  seg;
  logic [23:0] pden;
  logic [24:0] den;
  int          error_cnt, checks, starts;
  localparam logic [5:0] CODES [14] = '{6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
    6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h24, 6'h25, 6'h26, 6'h07, 6'h23};

  sweep_trigger dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out,
    .pin_oe_n, .pd_clock(ana[15]), .ref_div_out(ana[13]),
    .fb_div_out(ana[14]), .phase_lock_detect(ana[0]),
    .pump_monitor_good(ana[1]), .pump_monitor_high(ana[2]),
    .pump_monitor_low(ana[3]), .pump_up_pulse(ana[9]),
    .pump_down_pulse(ana[10]), .sweep_value, .segment_index(seg),
    .segment_pump_gain(ana[6]), .segment_flag_zero(ana[7]),
    .segment_flag_one(ana[8]), .fast_lock_active(ana[5]),
    .limit_exceeded(ana[4]), .repeat_count_done(ana[11]),
    .readback_data(ana[12]), .programmed_denominator(pden),
    .sweep_enable(en), .sweep_tick(tk), .sweep_start(start), .event_a(ea),
    .event_b(eb), .event_c(), .comparator_zero_hit(hit0),
    .comparator_one_hit(), .freq_deviation(fdev), .phase_deviation(pdev),
    .modulator_denominator(den));
  pin_far far (.pin_out, .pin_oe_n, .ext_lvl(ext), .pin_in);

  // clock and start pulse counter
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (start === 1'h1) starts++;

  task automatic chk(string n, logic [32:0] s, logic [32:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  // bus write: release each channel when taken, then wait response
  task automatic wr(logic [6:0] i, logic [7:0] d);
    logic a = 1'h1;
    logic w = 1'h1;
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      a = a & !awready;
      w = w & !wready;
    end while (a | w);
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    chk("bresp", bresp, 2'h0);
    @(posedge aclk);
  endtask

  task automatic rd(logic [6:0] i, logic [7:0] e, logic [1:0] r);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rdata", rdata, e);
    chk("rresp", rresp, r);
    @(posedge aclk);
  endtask

  task automatic t_regs;
    rd(7'h3A, 8'h00, 2'h0);
    wr(7'h45, 8'hA5);
    rd(7'h45, 8'hA5, 2'h0);
    rd(7'h30, 8'h00, 2'h2);
    $display("regs done");
  endtask

  // each of the 14 listed output codes alone high, then alone low
  task automatic t_route;
    for (int k = 0; k < 14; k++) begin
      wr(7'h53, {2'h0, CODES[k]});
      ana <= 16'h0001 << k;
      repeat (5) @(posedge aclk);
      chk("hi", {pin_oe_n[3], pin_out[3]}, 2'h1);
      ana <= ~(16'h0001 << k);
      repeat (5) @(posedge aclk);
      chk("lo", {pin_oe_n[3], pin_out[3]}, 2'h0);
    end
    wr(7'h53, 8'h0A);
    ana <= 16'h0003;
    repeat (5) @(posedge aclk);
    chk("lock", pin_out[3], 1'h1);
    ana <= 16'h0001;
    repeat (5) @(posedge aclk);
    chk("nolock", pin_out[3], 1'h0);
    wr(7'h53, 8'h14);
    repeat (2) @(posedge aclk);
    chk("rsv", pin_oe_n[3], 1'h1);
    wr(7'h53, 8'h00);
    repeat (2) @(posedge aclk);
    chk("gnd", {pin_oe_n[3], pin_out[3]}, 2'h0);
    $display("route done");
  endtask

  task automatic t_dev;
    wr(7'h47, 8'h5A);
    wr(7'h54, 8'h01);
    wr(7'h3A, 8'h80);
    repeat (2) @(posedge aclk);
    chk("ev a", ea, 1'h1);
    chk("fdev", fdev, 33'h5A);
    wr(7'h3A, 8'h84);
    repeat (2) @(posedge aclk);
    chk("pdev", pdev, 33'h5A);
    chk("fdev0", fdev, 33'h0);
    wr(7'h3A, 8'h04);
    repeat (2) @(posedge aclk);
    chk("pdev0", pdev, 33'h0);
    wr(7'h47, 8'h00);
    $display("deviation done");
  endtask

  task automatic t_cmp;
    wr(7'h40, 8'h02);
    seg <= 3'h1;
    sweep_value <= 33'h5;
    repeat (3) @(posedge aclk);
    chk("hit", hit0, 1'h1);
    seg <= 3'h0;
    repeat (3) @(posedge aclk);
    chk("masked", hit0, 1'h0);
    seg <= 3'h1;
    sweep_value <= 33'h100000000;
    repeat (3) @(posedge aclk);
    chk("neg", hit0, 1'h0);
    wr(7'h46, 8'h01);
    repeat (3) @(posedge aclk);
    chk("negthr", hit0, 1'h1);
    $display("compare done");
  endtask

  // pin 0 as trigger one input, edges taken on detector ticks, then key ticks counted
  task automatic t_trig;
    int na = 0;
    int nb = 0;
    int nt = 0;
    wr(7'h50, 8'h01);
    wr(7'h51, 8'h27);
    wr(7'h3B, 8'h09);
    wr(7'h3A, 8'h10);
    chk("rsv1", pin_oe_n[1], 1'h1);
    for (int v = 1; v >= 0; v--) begin
      ext <= 4'(v);
      repeat (4) @(posedge aclk);
      ana[15] <= 1'h1;
      repeat (6) begin
        @(posedge aclk);
        na += ea;
        nb += eb;
        nt += tk;
      end
      ana[15] <= 1'h0;
      repeat (3) @(posedge aclk);
    end
    chk("rise a", na, 33'h1);
    chk("fall b", nb, 33'h1);
    wr(7'h52, 8'h03);
    wr(7'h3A, 8'h12);
    ext <= 4'h4;
    repeat (6) begin
      @(posedge aclk);
      nt += tk;
    end
    chk("ticks", nt, 33'h3);
    $display("trigger done");
  endtask

  task automatic t_sweep;
    chk("den", den, 25'h0123456);
    wr(7'h55, 8'h01);
    wr(7'h3A, 8'h01);
    repeat (2) @(posedge aclk);
    chk("en", en, 1'h1);
    chk("den", den, 25'h1000000);
    wr(7'h55, 8'h07);
    repeat (3) @(posedge aclk);
    chk("starts", starts, 33'h1);
    $display("sweep done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reset, then the scenarios
  initial begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ana, ext, sweep_value, seg} = '0;
    wstrb = 4'hF;
    pden = 24'h123456;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    t_regs;
    t_route;
    t_dev;
    t_cmp;
    t_trig;
    t_sweep;
    finish_test;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    finish_test;
  end
endmodule
